//--- baud_chain_if.sv
// Settings and tick between the register block and the baud divider chain
interface baud_chain_if;
    logic       enable;
    logic       srcTick;
    logic [1:0] firstStageSel;
    logic [2:0] baudDivSel;
    logic [2:0] prescaleSel;
    logic [4:0] insertSel;
    logic       rtTick;

    modport ctrl  (output enable, srcTick, firstStageSel, baudDivSel, prescaleSel, insertSel, input rtTick);
    modport chain (input enable, srcTick, firstStageSel, baudDivSel, prescaleSel, insertSel, output rtTick);
endinterface : baud_chain_if

//--- baud_tick_chain.sv
// Four-stage baud divider: fractional prescaler, first stage, baud divisor, quarter
`include "serial_baud_gen_lin_break_map.svh"

module baud_tick_chain (
    input wire logic      clk_sys,
    input wire logic      reset,
    baud_chain_if.chain   bus
);

    logic [3:0] preCnt_r;
    logic [4:0] fracAcc_r;
    logic       extra_r;
    logic [3:0] preLast;
    logic       preTick;
    logic [3:0] firstCnt_r;
    logic [3:0] firstLast;
    logic       firstTick;
    logic [6:0] baudCnt_r;
    logic [6:0] baudLast;
    logic       baudTick;
    logic [1:0] quarterCnt_r;
    logic       rtTick_r;

    // ------------------------------------------------------------
    // Fractional prescaler
    // ------------------------------------------------------------
    always_comb begin
        preLast = {1'b0, bus.prescaleSel} + {3'h0, extra_r};
        if (bus.prescaleSel == 3'h0) begin
            preTick = bus.srcTick;
        end else begin
            preTick = bus.srcTick && (preCnt_r == preLast);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || !bus.enable) begin
            preCnt_r <= 4'h0;
        end else if (bus.srcTick) begin
            preCnt_r <= preTick ? 4'h0 : preCnt_r + 4'h1;
        end
    end

    // Accumulator carry spreads the inserted clocks evenly over the frame
    always_ff @(posedge clk_sys) begin
        if (reset || !bus.enable || bus.prescaleSel == 3'h0) begin
            fracAcc_r <= 5'h00;
            extra_r   <= 1'b0;
        end else if (preTick) begin
            {extra_r, fracAcc_r} <= {1'b0, fracAcc_r} + {1'b0, bus.insertSel};
        end
    end

    // ------------------------------------------------------------
    // First-stage divisor
    // ------------------------------------------------------------
    always_comb begin
        case (bus.firstStageSel)
            2'h0:    firstLast = `FIRST_LAST_DIV1;
            2'h1:    firstLast = `FIRST_LAST_DIV3;
            2'h2:    firstLast = `FIRST_LAST_DIV4;
            2'h3:    firstLast = `FIRST_LAST_DIV13;
            default: firstLast = `FIRST_LAST_DIV1;
        endcase
        firstTick = preTick && (firstCnt_r == firstLast);
    end

    always_ff @(posedge clk_sys) begin
        if (reset || !bus.enable) begin
            firstCnt_r <= 4'h0;
        end else if (preTick) begin
            firstCnt_r <= firstTick ? 4'h0 : firstCnt_r + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Baud divisor, power of two
    // ------------------------------------------------------------
    assign baudLast = 7'((8'h01 << bus.baudDivSel) - 8'h01);
    assign baudTick = firstTick && (baudCnt_r == baudLast);

    always_ff @(posedge clk_sys) begin
        if (reset || !bus.enable) begin
            baudCnt_r <= 7'h00;
        end else if (firstTick) begin
            baudCnt_r <= baudTick ? 7'h00 : baudCnt_r + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // Divide by four; sixteen of these make one bit
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset || !bus.enable) begin
            quarterCnt_r <= 2'h0;
            rtTick_r     <= 1'b0;
        end else begin
            rtTick_r <= baudTick && (quarterCnt_r == `RT_PER_BAUD_LAST);
            if (baudTick) begin
                quarterCnt_r <= quarterCnt_r + 2'h1;
            end
        end
    end

    assign bus.rtTick = rtTick_r;

endmodule : baud_tick_chain

//--- lin_node_model.sv
// Remote LIN node: drives the receive side and times transmitted breaks
module lin_node_model (
    input  wire logic       clk_sys,
    input  wire logic       rtTick,
    input  wire logic       txLine,
    output logic            rxLine,
    output logic [7:0]      rxByte,
    output logic            rxByteLoad
);
    timeunit 1ns;
    timeprecision 1ps;
    int   lowTicks = 0;
    logic prevTx   = 1'b1;
    initial begin
        rxLine = 1'b1;
        rxByte = 8'h00;
        rxByteLoad = 1'b0;
    end
    // Length of the last break on txLine, in rtTicks
    always @(negedge clk_sys) begin
        prevTx <= txLine;
        if (prevTx && !txLine)
            lowTicks <= int'(rtTick);
        else if (!txLine && rtTick)
            lowTicks <= lowTicks + 1;
    end
    task automatic dominant(input int ticks);
        int k;
        @(posedge clk_sys);
        rxLine <= 1'b0;
        k = 0;
        while (k < ticks) begin
            @(negedge clk_sys);
            if (rtTick === 1'b1) k++;
        end
        @(posedge clk_sys);
        rxLine <= 1'b1; // Pull-up once released
    endtask : dominant
    task automatic load(input logic [7:0] b);
        @(posedge clk_sys);
        rxByte <= b;
        rxByteLoad <= 1'b1;
        @(posedge clk_sys);
        rxByteLoad <= 1'b0;
        rxByte <= ~b;
    endtask : load
endmodule : lin_node_model

//--- serial_baud_gen_lin_break.sv
// Data buffer, baud-rate generator registers and LIN break control behind APB
`include "serial_baud_gen_lin_break_map.svh"

module serial_baud_gen_lin_break #(
    parameter int ADDR_WIDTH = 8
) (
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  oscTick,
    input  wire logic                  rxLine,
    input  wire logic [7:0]            rxByte,
    input  wire logic                  rxByteLoad,
    output logic [7:0]                 txByte,
    output logic                       txByteLoad,
    output logic                       txLine,
    output logic                       rtTick,
    output logic                       breakDetected
);

    serial_baud_pkg::byte_t     rxBuf_r;
    serial_baud_pkg::byte_t     txBuf_r;
    logic [7:0]                 baudSel_r;
    logic [7:0]                 prescale_r;
    logic                       enable_r;
    logic                       charLen_r;
    logic                       clkSrc_r;
    logic                       sendReq_r;
    logic [31:0]                prdata_r;
    logic                       pready_r;
    logic                       pslverr_r;
    logic                       txLoad_r;
    logic                       txLine_r;
    logic                       breakFlag_r;
    logic                       armed_r;
    logic [7:0]                 lowCnt_r;
    logic [7:0]                 genCnt_r;
    serial_baud_pkg::break_gen_e genState_r;
    logic                       rtTick_r;
    logic                       access;
    logic                       done;
    logic                       wrDone;
    logic                       rdData;
    logic                       mapped;
    logic [7:0]                 offset;
    logic [31:0]                readMux;
    logic                       linTx;
    logic                       linRx;
    logic [3:0]                 detBits;
    logic [3:0]                 genBits;
    logic [7:0]                 detLast;
    logic [7:0]                 genLast;
    logic                       detectHit;
    logic                       chainTick;

    baud_chain_if chainBus ();

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign offset = paddr[7:0];
    assign access = psel && penable;
    assign done   = access && pready_r;
    assign wrDone = done && pwrite && !pslverr_r;
    assign rdData = done && !pwrite && (offset == `OFS_DATA_BUFFER);

    always_comb begin
        mapped  = 1'b1;
        readMux = 32'h0000_0000;
        case (offset)
            `OFS_DATA_BUFFER:   readMux = {24'h00_0000, rxBuf_r};
            `OFS_BAUD_RATE_SEL: readMux = {24'h00_0000, baudSel_r};
            `OFS_BAUD_PRESCALE: readMux = {24'h00_0000, prescale_r};
            `OFS_CONTROL:       readMux = {28'h000_0000, sendReq_r, clkSrc_r, charLen_r, enable_r};
            `OFS_STATUS:        readMux = {29'h000_0000, !rxLine, genState_r == serial_baud_pkg::GEN_SEND,
                                           breakFlag_r};
            default:            mapped  = 1'b0;
        endcase
    end

    // One wait state: ready rises at the edge ending the first access cycle, transfer ends on the next edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (access && !pready_r) begin
            pready_r  <= 1'b1;
            pslverr_r <= !mapped;
            prdata_r  <= (pwrite || !mapped) ? 32'h0000_0000 : readMux;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Data buffer, untouched by reset
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rxByteLoad) begin
            rxBuf_r <= rxByte;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wrDone && offset == `OFS_DATA_BUFFER) begin
            txBuf_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            txLoad_r <= 1'b0;
        end else begin
            txLoad_r <= wrDone && offset == `OFS_DATA_BUFFER;
        end
    end

    // ------------------------------------------------------------
    // Baud and prescaler registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            baudSel_r  <= `BRS_RESET;
            prescale_r <= `BPS_RESET;
        end else if (wrDone) begin
            if (offset == `OFS_BAUD_RATE_SEL) begin
                baudSel_r <= pwdata[7:0];
            end
            if (offset == `OFS_BAUD_PRESCALE) begin
                prescale_r <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Control register; break request self-clears once taken
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            {sendReq_r, clkSrc_r, charLen_r, enable_r} <= `CTL_RESET;
        end else begin
            if (wrDone && offset == `OFS_CONTROL) begin
                enable_r  <= pwdata[`CTL_ENABLE_BIT];
                charLen_r <= pwdata[`CTL_CHAR_LEN_BIT];
                clkSrc_r  <= pwdata[`CTL_CLK_SRC_BIT];
            end
            if (wrDone && offset == `OFS_CONTROL && pwdata[`CTL_SEND_BREAK_BIT]) begin
                sendReq_r <= 1'b1;
            end else if (genState_r == serial_baud_pkg::GEN_SEND) begin
                sendReq_r <= 1'b0;
            end
        end
    end

    assign linTx = baudSel_r[`BRS_LIN_TX_BIT];
    assign linRx = baudSel_r[`BRS_LIN_RX_BIT];

    // ------------------------------------------------------------
    // Baud divider chain
    // ------------------------------------------------------------
    assign chainTick = clkSrc_r ? oscTick : 1'b1;

    assign chainBus.enable        = enable_r;
    assign chainBus.srcTick       = chainTick;
    assign chainBus.firstStageSel = baudSel_r[`BRS_FIRST_HI_BIT:`BRS_FIRST_LO_BIT];
    assign chainBus.baudDivSel    = baudSel_r[`BRS_BAUD_DIV_MSB:`BRS_BAUD_DIV_LSB];
    assign chainBus.prescaleSel   = prescale_r[`BPS_PRESCALE_MSB:`BPS_PRESCALE_LSB];
    assign chainBus.insertSel     = prescale_r[`BPS_INSERT_MSB:`BPS_INSERT_LSB];

    baud_tick_chain u_chain (
        .clk_sys (clk_sys),
        .reset   (reset),
        .bus     (chainBus)
    );

    // Same tick drives receiver and transmitter sampling
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rtTick_r <= 1'b0;
        end else begin
            rtTick_r <= chainBus.rtTick;
        end
    end

    // ------------------------------------------------------------
    // Break lengths
    // ------------------------------------------------------------
    assign detBits = (linRx ? `BREAK_BITS_LIN : `BREAK_BITS_NORMAL) + {3'h0, charLen_r};
    assign genBits = (linTx ? `BREAK_BITS_LIN : `BREAK_BITS_NORMAL) + {3'h0, charLen_r};
    assign detLast = {detBits, 4'h0} - 8'h01;
    assign genLast = {genBits, 4'h0} - 8'h01;

    // ------------------------------------------------------------
    // Break detection
    // ------------------------------------------------------------
    // Full bit count of low line needed, so a shorter zero character never trips it
    assign detectHit = enable_r && rtTick_r && !rxLine && armed_r && (lowCnt_r == detLast);

    always_ff @(posedge clk_sys) begin
        if (reset || rxLine || !enable_r) begin
            lowCnt_r <= 8'h00;
        end else if (rtTick_r && lowCnt_r != 8'hFF) begin
            lowCnt_r <= lowCnt_r + 8'h01;
        end
    end

    // Line must return high before another break can register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            armed_r <= 1'b0;
        end else if (rxLine) begin
            armed_r <= 1'b1;
        end else if (detectHit) begin
            armed_r <= 1'b0;
        end
    end

    // Set wins over the clear by a data read
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            breakFlag_r <= 1'b0;
        end else if (detectHit) begin
            breakFlag_r <= 1'b1;
        end else if (rdData) begin
            breakFlag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Break generation
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            genState_r <= serial_baud_pkg::GEN_IDLE;
            genCnt_r   <= 8'h00;
            txLine_r   <= 1'b1;
        end else begin
            case (genState_r)
                serial_baud_pkg::GEN_IDLE: begin
                    txLine_r <= 1'b1;
                    genCnt_r <= 8'h00;
                    if (sendReq_r && enable_r) begin
                        genState_r <= serial_baud_pkg::GEN_SEND;
                        txLine_r   <= 1'b0;
                    end
                end
                serial_baud_pkg::GEN_SEND: begin
                    if (!enable_r) begin
                        genState_r <= serial_baud_pkg::GEN_IDLE;
                        txLine_r   <= 1'b1;
                    end else if (rtTick_r) begin
                        if (genCnt_r == genLast) begin
                            genState_r <= serial_baud_pkg::GEN_IDLE;
                            txLine_r   <= 1'b1;
                        end else begin
                            genCnt_r <= genCnt_r + 8'h01;
                        end
                    end
                end
                default: begin
                    genState_r <= serial_baud_pkg::GEN_IDLE;
                    txLine_r   <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign txByte        = txBuf_r;
    assign txByteLoad    = txLoad_r;
    assign txLine        = txLine_r;
    assign rtTick        = rtTick_r;
    assign breakDetected = breakFlag_r;

endmodule : serial_baud_gen_lin_break

//--- serial_baud_gen_lin_break_asserts.sv
// Port-level checks for the serial baud and break block
module serial_baud_gen_lin_break_asserts #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic                  clk_sys,
    input wire logic                  reset,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  rxLine,
    input wire logic [7:0]            txByte,
    input wire logic                  txByteLoad,
    input wire logic                  txLine,
    input wire logic                  rtTick,
    input wire logic                  breakDetected
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire dataWr = pready && pwrite && !pslverr && paddr == ADDR_WIDTH'(8'h18);

    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after wait state");
    a_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
        else $error("pready outside access or too long");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response malformed");
    a_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data on a write");
    a_tx_load: assert property (dataWr |=> txByteLoad && txByte == $past(pwdata[7:0]))
        else $error("transmit byte not loaded");
    a_load_cause: assert property (txByteLoad |-> $past(dataWr))
        else $error("stray transmit load");
    a_reset_idle: assert property ($fell(reset) |-> txLine && !pready && !rtTick && !breakDetected)
        else $error("outputs not idle after reset");
    a_rt_spacing: assert property (rtTick |=> !rtTick [*3])
        else $error("rtTick faster than four source ticks");
    a_flag_cause: assert property ($rose(breakDetected) |-> $past(!rxLine))
        else $error("break flag without low line");
endmodule : serial_baud_gen_lin_break_asserts

bind serial_baud_gen_lin_break serial_baud_gen_lin_break_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (
    .clk_sys(clk_sys), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxLine(rxLine),
    .txByte(txByte), .txByteLoad(txByteLoad), .txLine(txLine), .rtTick(rtTick),
    .breakDetected(breakDetected));

//--- serial_baud_gen_lin_break_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SERIAL_BAUD_GEN_LIN_BREAK_MAP_SVH
`define SERIAL_BAUD_GEN_LIN_BREAK_MAP_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_DATA_BUFFER     8'h18
`define OFS_BAUD_RATE_SEL   8'h1C
`define OFS_BAUD_PRESCALE   8'h20
`define OFS_CONTROL         8'h24
`define OFS_STATUS          8'h28

// ------------------------------------------------------------
// baud_rate_select fields
// ------------------------------------------------------------
`define BRS_LIN_TX_BIT      7
`define BRS_LIN_RX_BIT      6
`define BRS_FIRST_HI_BIT    5
`define BRS_FIRST_LO_BIT    4
`define BRS_BAUD_DIV_MSB    2
`define BRS_BAUD_DIV_LSB    0
`define BRS_RESET           8'h00

// ------------------------------------------------------------
// baud_prescale_select fields
// ------------------------------------------------------------
`define BPS_PRESCALE_MSB    7
`define BPS_PRESCALE_LSB    5
`define BPS_INSERT_MSB      4
`define BPS_INSERT_LSB      0
`define BPS_RESET           8'h00

// ------------------------------------------------------------
// Control and status fields
// ------------------------------------------------------------
`define CTL_ENABLE_BIT      0
`define CTL_CHAR_LEN_BIT    1
`define CTL_CLK_SRC_BIT     2
`define CTL_SEND_BREAK_BIT  3
`define CTL_RESET           4'h0
`define STS_BREAK_FLAG_BIT  0
`define STS_BREAK_SEND_BIT  1
`define STS_LINE_LOW_BIT    2

// ------------------------------------------------------------
// Divider constants
// ------------------------------------------------------------
`define FIRST_LAST_DIV1     4'h0
`define FIRST_LAST_DIV3     4'h2
`define FIRST_LAST_DIV4     4'h3
`define FIRST_LAST_DIV13    4'hC
`define FRAC_FRAME_BITS     5
`define RT_PER_BAUD_LAST    2'h3
`define RT_PER_BIT_SHIFT    4

// ------------------------------------------------------------
// Break lengths in bit times
// ------------------------------------------------------------
`define BREAK_BITS_NORMAL   4'hA
`define BREAK_BITS_LIN      4'hB

`endif

//--- serial_baud_gen_lin_break_tb_top.sv
// Self-checking bench for the serial baud and break block
module serial_baud_gen_lin_break_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr, rdErr;
    logic        rxLine, rxByteLoad, txByteLoad, txLine, rtTick, breakDetected;
    logic        oscTick = 1'b0;
    logic [7:0]  paddr, rxByte, txByte;
    logic [31:0] pwdata, prdata, rdData;
    int          err_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    localparam logic [7:0] BRS_TAB [11] = '{0, 0, 0, 0, 0, 8'h10, 8'h20, 8'h30, 8'h07, 8'h13, 0};
    localparam logic [7:0] BPS_TAB [11] = '{0, 8'h1F, 8'hE0, 8'hE5, 8'h3F, 0, 0, 0, 0, 8'h21, 0};
    localparam logic [10:0] OSC_SEL = 11'h400;
    localparam int BPD_TAB [4] = '{1, 3, 4, 13};

    serial_baud_gen_lin_break #(.ADDR_WIDTH(8)) dut_u (
        .clk_sys(clk_sys), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .oscTick(oscTick),
        .rxLine(rxLine), .rxByte(rxByte), .rxByteLoad(rxByteLoad), .txByte(txByte),
        .txByteLoad(txByteLoad), .txLine(txLine), .rtTick(rtTick), .breakDetected(breakDetected));
    lin_node_model node_u (.clk_sys(clk_sys), .rtTick(rtTick), .txLine(txLine), .rxLine(rxLine),
        .rxByte(rxByte), .rxByteLoad(rxByteLoad));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) oscTick <= ~oscTick;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (err_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Ready, data and error are taken at the edge that sees ready high
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic t_regs();
        apb(1, 8'h1C, 32'hF7);
        apb(0, 8'h1C, 0);
        chk(rdData, 32'hF7);
        apb(1, 8'h20, 32'hE5);
        apb(0, 8'h20, 0);
        chk(rdData, 32'hE5);
        apb(1, 8'h30, 32'hFF);
        chk(rdErr, 1);
        apb(0, 8'h30, 0);
        chk({rdErr, rdData[30:0]}, 32'h80000000);
    endtask : t_regs
    task automatic t_data();
        node_u.load(8'h5A);
        apb(0, 8'h18, 0);
        chk(rdData, 32'h5A);
        apb(1, 8'h18, 32'hA5);
        @(negedge clk_sys);
        chk(txByte, 8'hA5);
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        apb(0, 8'h18, 0);
        chk(rdData, 32'h5A);
        chk(txByte, 8'hA5);
        apb(0, 8'h1C, 0);
        chk(rdData, 0);
        apb(0, 8'h20, 0);
        chk(rdData, 0);
    endtask : t_data
    task automatic t_div();
        int n, k, expCyc, pds;
        for (int i = 0; i < 11; i++) begin
            apb(1, 8'h24, 0);
            apb(1, 8'h1C, BRS_TAB[i]);
            apb(1, 8'h20, BPS_TAB[i]);
            apb(1, 8'h24, {29'h0, OSC_SEL[i], 2'b01});
            pds = BPS_TAB[i][7:5];
            expCyc = BPD_TAB[BRS_TAB[i][5:4]] * (1 << BRS_TAB[i][2:0]) * (OSC_SEL[i] ? 2 : 1)
                * (pds == 0 ? 32 : 32 * (pds + 1) + BPS_TAB[i][4:0]);
            n = 0;
            do begin
                @(negedge clk_sys);
                n++;
            end while (rtTick !== 1'b1 && n < 20000);
            k = 0;
            n = 0;
            while (k < 8 && n < 20000) begin
                @(negedge clk_sys);
                n++;
                if (rtTick === 1'b1) k++;
            end
            chk(32'(n), 32'(expCyc));
        end
    endtask : t_div
    task automatic t_lin();
        int n, bits;
        for (int mode = 0; mode < 4; mode++) begin
            for (int m = 0; m < 2; m++) begin
                apb(1, 8'h24, 0);
                apb(1, 8'h1C, {24'h0, mode[1:0], 6'h0});
                apb(1, 8'h20, 0);
                apb(1, 8'h24, 32'(1 + 2 * m));
                apb(1, 8'h24, 32'(9 + 2 * m));
                apb(0, 8'h28, 0);
                chk(rdData[2:1], 2'b01);
                n = 0;
                do begin
                    @(negedge clk_sys);
                    n++;
                end while (txLine !== 1'b1 && n < 5000 || n < 2);
                chk(32'((node_u.lowTicks + 8) / 16), 32'(10 + m + mode[1]));
                bits = 10 + m + mode[0];
                node_u.dominant(bits * 16 - 8);
                apb(0, 8'h28, 0);
                chk(rdData[0], 1'b0);
                node_u.dominant(bits * 16 + 8);
                apb(0, 8'h28, 0);
                chk(rdData[0], 1'b1);
                chk(breakDetected, 1'b1);
                apb(0, 8'h18, 0);
                apb(0, 8'h28, 0);
                chk(rdData[0], 1'b0);
            end
        end
    endtask : t_lin
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        t_regs();
        t_data();
        t_div();
        t_lin();
        end_sim();
    end
endmodule : serial_baud_gen_lin_break_tb_top

//--- serial_baud_pkg.sv
// Types shared by the baud generator and break control
package serial_baud_pkg;

    typedef enum logic [1:0] {
        GEN_IDLE = 2'b01,
        GEN_SEND = 2'b10
    } break_gen_e;

    typedef logic [7:0] byte_t;

endpackage : serial_baud_pkg
